// file: rtl/jbst_pkg.sv
// Types and the instruction decoder of the boundary-scan test access port.
package jbst_pkg;
  `include "jbst_regs.svh"

  // --------------------------------------------------------------------------
  // Controller states, 4-bit encoding
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    JBST_TLR    = 4'hF,
    JBST_RTI    = 4'hC,
    JBST_SEL_DR = 4'h7,
    JBST_CAP_DR = 4'h6,
    JBST_SH_DR  = 4'h2,
    JBST_EX1_DR = 4'h1,
    JBST_PAU_DR = 4'h3,
    JBST_EX2_DR = 4'h0,
    JBST_UPD_DR = 4'h5,
    JBST_SEL_IR = 4'h4,
    JBST_CAP_IR = 4'hE,
    JBST_SH_IR  = 4'hA,
    JBST_EX1_IR = 4'h9,
    JBST_PAU_IR = 4'hB,
    JBST_EX2_IR = 4'h8,
    JBST_UPD_IR = 4'hD
  } jbst_tap_st_t;

  // Selected data register, one-hot
  typedef enum logic [3:0] {
    JBST_SEL_BYP  = 4'h1,
    JBST_SEL_ID   = 4'h2,
    JBST_SEL_USER = 4'h4,
    JBST_SEL_BSR  = 4'h8
  } jbst_dr_sel_t;

  // Decoded instruction
  typedef struct packed {
    jbst_dr_sel_t sel;       // Data register between TDI and TDO
    logic         drive_bsr; // Pads driven from update cells
    logic         hiz;       // All pad drivers off
  } jbst_dec_t;

  // --------------------------------------------------------------------------
  // Opcode decoder
  // --------------------------------------------------------------------------
  function automatic jbst_dec_t jbst_decode(input logic [`JBST_IR_W-1:0] op);
    jbst_dec_t d;
    d = '{sel: JBST_SEL_BYP, drive_bsr: 1'b0, hiz: 1'b0};
    case (op)
      `JBST_OP_EXTEST: begin
        d.sel       = JBST_SEL_BSR;
        d.drive_bsr = 1'b1;
      end
      `JBST_OP_SAMPLE:   d.sel = JBST_SEL_BSR;
      `JBST_OP_CLAMP:    d.drive_bsr = 1'b1;
      `JBST_OP_HIGHZ:    d.hiz = 1'b1;
      `JBST_OP_IDCODE:   d.sel = JBST_SEL_ID;
      `JBST_OP_USERCODE: d.sel = JBST_SEL_USER;
      default:           d.sel = JBST_SEL_BYP;
    endcase
    return d;
  endfunction
endpackage

// file: rtl/jbst_regs.svh
// Constants of the boundary-scan test access port: opcodes, widths, capture values.
`ifndef JBST_REGS_SVH
`define JBST_REGS_SVH

// ----------------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------------
`define JBST_IR_W         8
`define JBST_IR_CAPTURE   8'h01
`define JBST_OP_EXTEST    8'h00
`define JBST_OP_SAMPLE    8'h01
`define JBST_OP_CLAMP     8'h05
`define JBST_OP_HIGHZ     8'h07
`define JBST_OP_USERCODE  8'h0E
`define JBST_OP_IDCODE    8'h0F
`define JBST_OP_BYPASS    8'hFF

// ----------------------------------------------------------------------------
// Data registers
// ----------------------------------------------------------------------------
`define JBST_ID_W         32
`define JBST_BYP_CAPTURE  1'b0
`define JBST_CELLS_PER_IO 3
`define JBST_CELL_IN      0
`define JBST_CELL_OUT     1
`define JBST_CELL_EN      2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define JBST_TLR_EDGES    5
`define JBST_SYNC_STAGES  2

`endif

// file: rtl/jbst_sync.sv
// Two-stage level synchroniser for a bus of independent bits.
`timescale 1ns/1ps
`default_nettype none
module jbst_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1; // Metastable stage, read only by s2
    logic [W-1:0] s2; // Settled stage
  } jbst_sync_t;

  jbst_sync_t r;      // Registered state
  jbst_sync_t next_r; // Next state

  // Shift through both stages
  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    if (rst) begin
      next_r = '0;
    end
  end

  // Register the stages
  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign q = r.s2;
endmodule
`default_nettype wire

// file: rtl/jbst_tap.sv
// Boundary-scan test access port: instruction and data registers, pad control.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Test port with controller, instruction and data registers
// - Unprogrammed device keeps global I/O enable off
// - SAMPLE while unprogrammed leaves all I/O untouched
// - Support EXTEST, SAMPLE/PRELOAD and BYPASS
// - Decode 00, 01, 05, 07, FF opcodes
// - IDCODE at 0F, USERCODE at 0E
// - Undriven TMS, TDI, TRST read high; this module has no pull-ups on them
// - Sixteen-state controller stepped on rising TCK
// - Controller driven by TMS and TCK, reset also by TRST and power-up reset
// - Power-up enters Test-Logic-Reset
// - Five TMS-high edges force Test-Logic-Reset
// - TRST resets controller asynchronously
// - Bypass, identification, boundary registers; bypass default
// - 32-bit identification register with four fields
// - Three scan cells per I/O
// - One chain from TDI to TDO
// - Cells capture and drive core and buffer paths; update cells drive only pad_out and pad_oe, core_in follows the pads only while programmed
module jbst_tap
  import jbst_pkg::*;
#(
  parameter int                  IO_COUNT = 4,
  parameter logic [`JBST_ID_W-1:0] ID_CODE  = 32'h1000_0001, // Arbitrary value
  parameter logic [`JBST_ID_W-1:0] USER_CODE = 32'h0000_0000
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                tck,
  input  wire logic                trst_n,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdo_oe,
  input  wire logic                cfg_programmed,
  output logic                     io_en,
  input  wire logic [IO_COUNT-1:0] core_out,
  input  wire logic [IO_COUNT-1:0] core_oe,
  output logic      [IO_COUNT-1:0] core_in,
  input  wire logic [IO_COUNT-1:0] pad_in,
  output logic      [IO_COUNT-1:0] pad_out,
  output logic      [IO_COUNT-1:0] pad_oe
);
  localparam int BSR_W = `JBST_CELLS_PER_IO * IO_COUNT; // Boundary chain length

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Gather one kind of cell across all I/Os
  function automatic logic [IO_COUNT-1:0] cells(input logic [BSR_W-1:0] v, input int k);
    logic [IO_COUNT-1:0] c;
    c = '0;
    for (int i = 0; i < IO_COUNT; i++) begin
      c[i] = v[`JBST_CELLS_PER_IO*i + k];
    end
    return c;
  endfunction

  // --------------------------------------------------------------------------
  // Test-clock domain state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`JBST_IR_W-1:0] ir;      // Active instruction
    logic [`JBST_IR_W-1:0] ir_sh;   // Instruction shift stage
    logic                  byp;     // Bypass cell
    logic [`JBST_ID_W-1:0] id_sh;   // Identification or user code shifter
    logic [BSR_W-1:0]      bsr_sh;  // Boundary capture and shift stage
    logic [BSR_W-1:0]      bsr_upd; // Boundary update stage
    logic                  upd_tgl; // Flips on each boundary update
    logic                  drv;     // Pads follow update cells
    logic                  hiz;     // Pads floated
  } jbst_tck_t;

  // Falling-edge output stage
  typedef struct packed {
    logic tdo;    // Serial data out
    logic tdo_oe; // Driver enable
  } jbst_neg_t;

  // Core-clock domain state
  typedef struct packed {
    logic [BSR_W-1:0]    cap;      // Parallel capture word
    logic [BSR_W-1:0]    upd;      // Update cells as seen by pads
    logic                tgl_seen; // Last update toggle taken
    logic                io_en;    // Global I/O enable
    logic [IO_COUNT-1:0] pad_out;  // Pad output value
    logic [IO_COUNT-1:0] pad_oe;   // Pad driver enable
    logic [IO_COUNT-1:0] core_in;  // Input buffer towards core
  } jbst_core_t;

  jbst_tck_t  t;           // Test-clock state
  jbst_tck_t  next_t;      // Next test-clock state
  jbst_neg_t  n;           // Output stage
  jbst_neg_t  next_n;      // Next output stage
  jbst_core_t c;           // Core state
  jbst_core_t next_c;      // Next core state
  jbst_tap_st_t st;        // Controller state
  jbst_dec_t  dec;         // Decoded active instruction
  logic       pwr_rst_tck; // Power-up reset seen on test clock
  logic [BSR_W-1:0] cap_tck;   // Capture word on test clock
  logic [IO_COUNT-1:0] pad_s;  // Synchronised pad inputs
  logic [2:0] ctl_s;       // Toggle, drive and float on core clock

  // --------------------------------------------------------------------------
  // Crossings
  // --------------------------------------------------------------------------
  // Power-up reset into the test-clock domain
  jbst_sync #(.W(1)) u_rst_sync (
    .clk (tck),
    .rst (1'b0),
    .d   (rst),
    .q   (pwr_rst_tck)
  );

  // Parallel capture word into the test-clock domain
  jbst_sync #(.W(BSR_W)) u_cap_sync (
    .clk (tck),
    .rst (pwr_rst_tck),
    .d   (c.cap),
    .q   (cap_tck)
  );

  // Pad pins into the core domain
  jbst_sync #(.W(IO_COUNT)) u_pad_sync (
    .clk (core_clk),
    .rst (rst),
    .d   (pad_in),
    .q   (pad_s)
  );

  // Mode levels and update toggle into the core domain
  jbst_sync #(.W(3)) u_ctl_sync (
    .clk (core_clk),
    .rst (rst),
    .d   ({t.upd_tgl, t.drv, t.hiz}),
    .q   (ctl_s)
  );

  // --------------------------------------------------------------------------
  // Controller
  // --------------------------------------------------------------------------
  // TMS high keeps reset, TRST high releases it; no pull-ups here, so both must be driven
  jbst_tap_fsm u_fsm (
    .tck     (tck),
    .trst_n  (trst_n),
    .pwr_rst (pwr_rst_tck),
    .tms     (tms),
    .st      (st)
  );

  assign dec = jbst_decode(t.ir);

  // --------------------------------------------------------------------------
  // Instruction and data registers, rising TCK
  // --------------------------------------------------------------------------
  always_comb begin
    next_t = t;
    case (st)
      JBST_TLR: next_t.ir = `JBST_OP_IDCODE;
      JBST_CAP_IR: next_t.ir_sh = `JBST_IR_CAPTURE;
      JBST_SH_IR: next_t.ir_sh = {tdi, t.ir_sh[`JBST_IR_W-1:1]};
      JBST_UPD_IR: next_t.ir = t.ir_sh;
      JBST_CAP_DR: begin
        case (dec.sel)
          JBST_SEL_ID:   next_t.id_sh = ID_CODE;
          JBST_SEL_USER: next_t.id_sh = USER_CODE;
          JBST_SEL_BSR:  next_t.bsr_sh = cap_tck;
          default:       next_t.byp = `JBST_BYP_CAPTURE;
        endcase
      end
      JBST_SH_DR: begin
        case (dec.sel)
          JBST_SEL_ID,
          JBST_SEL_USER: next_t.id_sh = {tdi, t.id_sh[`JBST_ID_W-1:1]};
          JBST_SEL_BSR:  next_t.bsr_sh = {tdi, t.bsr_sh[BSR_W-1:1]};
          default:       next_t.byp = tdi;
        endcase
      end
      JBST_UPD_DR: begin
        if (dec.sel == JBST_SEL_BSR) begin
          next_t.bsr_upd = t.bsr_sh; // Preload for EXTEST and CLAMP
          next_t.upd_tgl = ~t.upd_tgl;
        end
      end
      default: next_t.byp = t.byp;
    endcase
    // Registered mode levels so the crossing never sees decode glitches
    next_t.drv = jbst_decode(next_t.ir).drive_bsr;
    next_t.hiz = jbst_decode(next_t.ir).hiz;
    if (pwr_rst_tck) begin
      next_t    = '0;
      next_t.ir = `JBST_OP_IDCODE;
    end
  end

  // Test-clock register, TRST clears it at once and loads IDCODE
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      t    <= '0;
      t.ir <= `JBST_OP_IDCODE;
    end else begin
      t <= next_t;
    end
  end

  // --------------------------------------------------------------------------
  // Serial output, falling TCK
  // --------------------------------------------------------------------------
  always_comb begin
    next_n = '0;
    if (st == JBST_SH_IR) begin
      next_n.tdo    = t.ir_sh[0];
      next_n.tdo_oe = 1'b1;
    end else if (st == JBST_SH_DR) begin
      next_n.tdo_oe = 1'b1;
      case (dec.sel)
        JBST_SEL_ID,
        JBST_SEL_USER: next_n.tdo = t.id_sh[0];
        JBST_SEL_BSR:  next_n.tdo = t.bsr_sh[0];
        default:       next_n.tdo = t.byp;
      endcase
    end
    if (pwr_rst_tck) begin
      next_n = '0;
    end
  end

  // Output stage register
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      n <= '0;
    end else begin
      n <= next_n;
    end
  end

  assign tdo    = n.tdo;
  assign tdo_oe = n.tdo_oe;

  // --------------------------------------------------------------------------
  // Pad and core side, core clock
  // --------------------------------------------------------------------------
  always_comb begin
    next_c         = c;
    next_c.io_en   = cfg_programmed;
    next_c.core_in = cfg_programmed ? pad_s : '0;
    // Capture input buffer, core output and core enable per I/O
    for (int i = 0; i < IO_COUNT; i++) begin
      next_c.cap[`JBST_CELLS_PER_IO*i + `JBST_CELL_IN]  = cfg_programmed & pad_s[i];
      next_c.cap[`JBST_CELLS_PER_IO*i + `JBST_CELL_OUT] = core_out[i];
      next_c.cap[`JBST_CELLS_PER_IO*i + `JBST_CELL_EN]  = core_oe[i];
    end
    // Take the update word once its toggle has settled here
    if (ctl_s[2] != c.tgl_seen) begin
      next_c.upd      = t.bsr_upd;
      next_c.tgl_seen = ctl_s[2];
    end
    if (ctl_s[1]) begin
      next_c.pad_out = cells(c.upd, `JBST_CELL_OUT);
      next_c.pad_oe  = cells(c.upd, `JBST_CELL_EN);
    end else if (ctl_s[0]) begin
      next_c.pad_out = '0;
      next_c.pad_oe  = '0;
    end else begin
      next_c.pad_out = core_out;
      next_c.pad_oe  = core_oe;
    end
    // Nothing, not even SAMPLE, wakes the pads while unprogrammed
    if (!cfg_programmed) begin
      next_c.pad_out = '0;
      next_c.pad_oe  = '0;
    end
    if (rst) begin
      next_c = '0;
    end
  end

  // Core register
  always_ff @(posedge core_clk) begin
    c <= next_c;
  end

  assign io_en   = c.io_en;
  assign pad_out = c.pad_out;
  assign pad_oe  = c.pad_oe;
  assign core_in = c.core_in;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_ir_update: assert property (
    @(posedge tck) disable iff (!trst_n || pwr_rst_tck)
    st == JBST_UPD_IR |=> t.ir == $past(t.ir_sh))
    else $error("Instruction not loaded at Update-IR");

  a_reset_idcode: assert property (
    @(posedge tck) disable iff (!trst_n || pwr_rst_tck)
    st == JBST_TLR |=> t.ir == `JBST_OP_IDCODE)
    else $error("Reset did not select the identification instruction");

  a_tdo_window: assert property (
    @(posedge tck) disable iff (!trst_n || pwr_rst_tck)
    tdo_oe == (st == JBST_SH_IR || st == JBST_SH_DR))
    else $error("TDO driven outside a shift state");

  a_bypass_shift: assert property (
    @(posedge tck) disable iff (!trst_n || pwr_rst_tck)
    st == JBST_SH_DR && dec.sel == JBST_SEL_BYP |=> t.byp == $past(tdi))
    else $error("Bypass cell did not take TDI");

  a_unprog_off: assert property (
    @(posedge core_clk) disable iff (rst)
    !$past(cfg_programmed) |-> !io_en && pad_oe == '0 && core_in == '0)
    else $error("I/O active while unprogrammed");

  a_highz_float: assert property (
    @(posedge core_clk) disable iff (rst)
    $past(ctl_s[0]) && !$past(ctl_s[1]) |-> pad_oe == '0)
    else $error("Pad driven during HIGHZ");

  a_sample_transp: assert property (
    @(posedge core_clk) disable iff (rst)
    $past(cfg_programmed) && !$past(ctl_s[1]) && !$past(ctl_s[0])
      |-> pad_out == $past(core_out) && pad_oe == $past(core_oe))
    else $error("Pads not following core in functional mode");
endmodule
`default_nettype wire

// file: rtl/jbst_tap_fsm.sv
// Sixteen-state test access port controller stepped by TMS on rising TCK.
`timescale 1ns/1ps
`default_nettype none
module jbst_tap_fsm
  import jbst_pkg::*;
(
  input  wire logic   tck,
  input  wire logic   trst_n,
  input  wire logic   pwr_rst,
  input  wire logic   tms,
  output jbst_tap_st_t st
);
  jbst_tap_st_t next_st; // Next controller state

  // --------------------------------------------------------------------------
  // Transition table, TMS high always heads toward reset
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    case (st)
      JBST_TLR:    next_st = tms ? JBST_TLR    : JBST_RTI;
      JBST_RTI:    next_st = tms ? JBST_SEL_DR : JBST_RTI;
      JBST_SEL_DR: next_st = tms ? JBST_SEL_IR : JBST_CAP_DR;
      JBST_CAP_DR: next_st = tms ? JBST_EX1_DR : JBST_SH_DR;
      JBST_SH_DR:  next_st = tms ? JBST_EX1_DR : JBST_SH_DR;
      JBST_EX1_DR: next_st = tms ? JBST_UPD_DR : JBST_PAU_DR;
      JBST_PAU_DR: next_st = tms ? JBST_EX2_DR : JBST_PAU_DR;
      JBST_EX2_DR: next_st = tms ? JBST_UPD_DR : JBST_SH_DR;
      JBST_UPD_DR: next_st = tms ? JBST_SEL_DR : JBST_RTI;
      JBST_SEL_IR: next_st = tms ? JBST_TLR    : JBST_CAP_IR;
      JBST_CAP_IR: next_st = tms ? JBST_EX1_IR : JBST_SH_IR;
      JBST_SH_IR:  next_st = tms ? JBST_EX1_IR : JBST_SH_IR;
      JBST_EX1_IR: next_st = tms ? JBST_UPD_IR : JBST_PAU_IR;
      JBST_PAU_IR: next_st = tms ? JBST_EX2_IR : JBST_PAU_IR;
      JBST_EX2_IR: next_st = tms ? JBST_UPD_IR : JBST_SH_IR;
      JBST_UPD_IR: next_st = tms ? JBST_SEL_DR : JBST_RTI;
      default:     next_st = JBST_TLR;
    endcase
    if (pwr_rst) begin
      next_st = JBST_TLR;
    end
  end

  // State register, TRST acts without a clock edge
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      st <= JBST_TLR;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_tms_reset: assert property (
    @(posedge tck) disable iff (!trst_n || pwr_rst)
    tms [*5] |=> st == JBST_TLR)
    else $error("Five TMS-high edges did not reach Test-Logic-Reset");

  a_trst_async: assert property (
    @(posedge tck) disable iff (pwr_rst)
    !trst_n |-> st == JBST_TLR)
    else $error("Controller left Test-Logic-Reset while TRST was active");
endmodule
`default_nettype wire

// file: sim/jbst_host.sv
// Test host model: drives test clock, mode, data and test reset of the port.
`timescale 1ns/1ps
`default_nettype none
module jbst_host (
  output var logic tck,
  output var logic trst_n,
  output var logic tms,
  output var logic tdi,
  input  wire logic tdo
);
  // Idle levels match the pull-ups; clock stands low outside frames
  initial begin
    tck    = 1'b0;
    trst_n = 1'b1;
    tms    = 1'b1;
    tdi    = 1'b1;
  end

  // One clock: mode and data set while low, data out taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #6;
    o   = tdo;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask

  // Mode sequence, bit 0 first, data held high
  task automatic walk(input logic [31:0] pat, input int n);
    logic o;
    for (int k = 0; k < n; k++) begin
      step(pat[k], 1'b1, o);
    end
  endtask

  // Five mode-high clocks, then one low clock into idle
  task automatic tlr();
    walk(32'h0000_001F, 6);
  endtask

  // Test reset level, no clock needed
  task automatic set_trst(input logic v);
    trst_n = v;
  endtask

  // Scan from idle: n bits LSB first, then update and back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    walk(ir ? 32'h3 : 32'h1, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    walk(32'h1, 2);
  endtask
endmodule
`default_nettype wire

// file: sim/tb_jbst_tap.sv
// Self-checking testbench of the boundary-scan test access port.
`timescale 1ns/1ps
`default_nettype none
`include "jbst_regs.svh"
module tb_jbst_tap;
  localparam int          N   = 4;
  localparam logic [31:0] IDC = 32'h1000_0001; // Arbitrary value
  localparam logic [31:0] UC  = 32'h0000_5A5A; // Arbitrary value
  logic           core_clk;
  logic           rst;
  logic           cfg_programmed;
  logic [N-1:0]   core_out, core_oe, pad_in;
  wire logic      tck, trst_n, tms, tdi, tdo, tdo_oe, io_en;
  wire logic [N-1:0] core_in, pad_out, pad_oe;
  logic [31:0]    seed, d, r, w;
  logic [7:0]     ops [8] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'h0E, 8'h0F, 8'hFF, 8'h3C};
  logic [7:0]     mode [4] = '{8'h00, 8'h05, 8'h07, 8'hFF};
  int             errors = 0;
  int             check_count = 0;
  int             cyc = 0;

  // ---------------------------------------------------------------------------
  // Design, host model, clock
  // ---------------------------------------------------------------------------
  jbst_tap #(.IO_COUNT(N), .ID_CODE(IDC), .USER_CODE(UC)) u_dut (
    .core_clk(core_clk), .rst(rst), .tck(tck), .trst_n(trst_n), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .cfg_programmed(cfg_programmed),
    .io_en(io_en), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  jbst_host u_host (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Data path word for an opcode, core inputs all zero
  function automatic logic [31:0] dr_exp(input logic [7:0] op, input logic [31:0] din);
    case (op)
      `JBST_OP_IDCODE:                 return IDC;
      `JBST_OP_USERCODE:               return UC;
      `JBST_OP_EXTEST, `JBST_OP_SAMPLE: return {din[19:0], 12'h000};
      default:                         return {din[30:0], 1'b0};
    endcase
  endfunction
  // Capture word: input, output, enable cell per pad
  function automatic logic [31:0] bsr_exp(input logic en, input logic [N-1:0] pi, co, ce);
    logic [31:0] b;
    b = '0;
    for (int i = 0; i < N; i++) begin
      b[3*i]   = pi[i] & en;
      b[3*i+1] = co[i];
      b[3*i+2] = ce[i];
    end
    return b;
  endfunction
  // Pads driven from update cells: {oe, out}
  function automatic logic [31:0] upd_pads(input logic [31:0] u);
    logic [31:0] p;
    p = '0;
    for (int i = 0; i < N; i++) begin
      p[i]   = u[3*i+1];
      p[N+i] = u[3*i+2];
    end
    return p;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 32'hA59CDD2C;
    rst = 1'b1;
    cfg_programmed = 1'b0;
    core_out = '0;
    core_oe = '0;
    pad_in = '0;
    // Test reset pulse first: clears the test-clock side before any clock edge
    u_host.set_trst(1'b0);
    #3;
    u_host.set_trst(1'b1);
    fork
      u_host.tlr();
      repeat (6) @(posedge core_clk);
    join
    @(posedge core_clk) rst <= 1'b0;
    // Two clocks drain the reset synchroniser, the third enters idle
    u_host.walk(32'h0, 3);
    u_host.scan(1'b0, 32, rnd(), d);
    chk(d, IDC);
    u_host.scan(1'b1, 8, 32'hFF, d);
    chk(d, 32'h01);
    // Every opcode, unprogrammed, core inputs zero
    foreach (ops[i]) begin
      r = rnd();
      u_host.scan(1'b1, 8, 32'(ops[i]), d);
      u_host.scan(1'b0, 32, r, d);
      chk(d, dr_exp(ops[i], r));
      chk(32'(tdo_oe), 32'h0);
    end
    // Unprogrammed: pads, buffers and enable stay off
    repeat (8) begin
      @(posedge core_clk);
      core_out <= N'(rnd());
      core_oe <= N'(rnd());
      pad_in <= N'(rnd());
      @(negedge core_clk);
      chk(32'({io_en, pad_out, pad_oe, core_in}), 32'h0);
    end
    @(posedge core_clk);
    core_out <= '0;
    core_oe <= '0;
    pad_in <= '1;
    u_host.scan(1'b1, 8, 32'(`JBST_OP_SAMPLE), d);
    u_host.scan(1'b0, 3 * N, 32'h0, d);
    chk(d, 32'h0);
    chk(32'({io_en, pad_out, pad_oe, core_in}), 32'h0);
    // Programmed: functional pad path
    @(posedge core_clk) cfg_programmed <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(32'(io_en), 32'h1);
    repeat (10) begin
      @(posedge core_clk);
      core_out <= N'(rnd());
      core_oe <= N'(rnd());
      @(posedge core_clk);
      @(negedge core_clk);
      chk(32'({pad_oe, pad_out}), 32'({core_oe, core_out}));
    end
    chk(32'(core_in), 32'(pad_in));
    // Sample capture with preload, then pad modes
    w = rnd();
    u_host.scan(1'b1, 8, 32'(`JBST_OP_SAMPLE), d);
    u_host.scan(1'b0, 3 * N, w, d);
    chk(d, bsr_exp(1'b1, pad_in, core_out, core_oe));
    foreach (mode[i]) begin
      u_host.scan(1'b1, 8, 32'(mode[i]), d);
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      chk(32'({pad_oe, pad_out}), i == 2 ? 32'h0 :
          i == 3 ? 32'({core_oe, core_out}) : upd_pads(w));
    end
    // Forced reset from random controller states
    repeat (4) begin
      u_host.scan(1'b1, 8, 32'hFF, d);
      r = rnd();
      u_host.walk(r, 4 + 32'(r[31:28]));
      u_host.tlr();
      u_host.scan(1'b0, 32, rnd(), d);
      chk(d, IDC);
    end
    // Test reset in mid-shift, no clock
    u_host.scan(1'b1, 8, 32'hFF, d);
    u_host.walk(32'h1, 3);
    #1;
    chk(32'(tdo_oe), 32'h1);
    u_host.set_trst(1'b0);
    #2;
    chk(32'({tdo_oe, tdo}), 32'h0);
    u_host.set_trst(1'b1);
    u_host.walk(32'h0, 1);
    u_host.scan(1'b0, 32, rnd(), d);
    chk(d, IDC);
    stop_test();
  end
endmodule
`default_nettype wire
